// ==== inc/cws_params.svh ====
// Constants of the complementary waveform block: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name wherever a constant is needed.
`ifndef CWS_PARAMS_SVH
`define CWS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CWS_OFS_CONTROL0      8'h00
`define CWS_OFS_CONTROL1      8'h04
`define CWS_OFS_DATA_SEL      8'h08
`define CWS_OFS_AUTOSHUT0     8'h0C
`define CWS_OFS_AUTOSHUT1     8'h10
`define CWS_OFS_RISE_DB       8'h14
`define CWS_OFS_FALL_DB       8'h18
`define CWS_OFS_CLK_SEL       8'h1C
`define CWS_OFS_STATUS        8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CWS_BIT_EN            7
`define CWS_BIT_SHUTDOWN      7
`define CWS_BIT_RESTART       6
`define CWS_BIT_OVR_BD        4
`define CWS_BIT_OVR_AC        2
`define CWS_BIT_STEER         4

// ----------------------------------------------------------------
// Mode codes and override codes
// ----------------------------------------------------------------
`define CWS_MODE_STEER_SYNC   3'h0
`define CWS_MODE_STEER_ASYNC  3'h1
`define CWS_MODE_FULL_FWD     3'h2
`define CWS_MODE_FULL_REV     3'h3
`define CWS_MODE_HALF_BRIDGE  3'h4
`define CWS_MODE_PUSH_PULL    3'h5
`define CWS_OVR_INACTIVE      2'h0
`define CWS_OVR_FLOAT         2'h1
`define CWS_OVR_LOW           2'h2
`define CWS_OVR_HIGH          2'h3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CWS_RST_DB            6'h00
`define CWS_RST_SHUTDOWN      1'b1
`define CWS_CLK_MHZ           50
`define CWS_OSC_MHZ           16
`define CWS_OSC_DIV           (`CWS_CLK_MHZ / `CWS_OSC_MHZ)

`endif

// ==== inc/cws_pkg.sv ====
// Types shared by the complementary waveform block.
// Assumes cws_params.svh is on the include path.
`include "cws_params.svh"

package cws_pkg;

  // ----------------------------------------------------------------
  // Output forming modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CWS_STEER_SYNC  = `CWS_MODE_STEER_SYNC,
    CWS_STEER_ASYNC = `CWS_MODE_STEER_ASYNC,
    CWS_FULL_FWD    = `CWS_MODE_FULL_FWD,
    CWS_FULL_REV    = `CWS_MODE_FULL_REV,
    CWS_HALF_BRIDGE = `CWS_MODE_HALF_BRIDGE,
    CWS_PUSH_PULL   = `CWS_MODE_PUSH_PULL
  } cws_mode_type;

  typedef logic [5:0] cws_count_type;
  typedef logic [3:0] cws_quad_type;

endpackage

// ==== inc/cws_db_if.sv ====
// Carrier between the waveform core and one dead-band delay stage.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none

interface cws_db_if;
  import cws_pkg::*;
  logic          raw;
  cws_count_type rise_cnt;
  cws_count_type fall_cnt;
  logic          tick;
  logic          delayed;

  modport owner (output raw, rise_cnt, fall_cnt, tick, input delayed);
  modport delay (input raw, rise_cnt, fall_cnt, tick, output delayed);
endinterface // cws_db_if

`default_nettype wire

// ==== src/cws_deadband.sv ====
// One dead-band delay stage: delays each edge of its input by the
// count for that edge direction, measured in module clock ticks.
// Assumes tick is a one-cycle enable pulse on pclk.
`timescale 1ns/100ps
`default_nettype none

module cws_deadband
  import cws_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  cws_db_if.delay   db
);
  import cws_pkg::*;

  typedef struct packed {
    logic          out;
    logic          pend;
    cws_count_type cnt;
  } cws_db_state_type;

  cws_db_state_type s_q;
  cws_db_state_type s_d;
  cws_count_type    sel;

  // ----------------------------------------------------------------
  // Edge delay: n counts give n to n+1 tick periods
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    sel = db.raw ? db.rise_cnt : db.fall_cnt;
    if (db.raw == s_q.out) begin
      s_d.pend = 1'b0;                      // Glitch shorter than delay
    end else if (!s_q.pend) begin
      if (sel == `CWS_RST_DB) begin
        s_d.out = db.raw;                   // see [RULE_16]
      end else begin
        s_d.cnt  = sel;                     // see [RULE_12]
        s_d.pend = 1'b1;
      end
    end else if (db.tick) begin
      if (s_q.cnt == `CWS_RST_DB) begin
        s_d.out  = db.raw;                  // see [RULE_16]
        s_d.pend = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign db.delayed = s_q.out;
endmodule // cws_deadband

`default_nettype wire

// ==== src/cws_shutdown.sv ====
// Shutdown flag: set by enabled sources or software, cleared by
// software or by auto-restart once every enabled source is quiet.
// Assumes sources are synchronous to pclk and active high.
`timescale 1ns/100ps
`default_nettype none

module cws_shutdown
  import cws_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire cws_quad_type shut_src,
  input  wire cws_quad_type shut_en,
  input  wire logic         restart_en,
  input  wire logic         sw_wr,
  input  wire logic         sw_val,
  output logic              shut
);
  import cws_pkg::*;

  typedef struct packed {
    logic shut;
  } cws_sd_state_type;

  cws_sd_state_type s_q;
  cws_sd_state_type s_d;
  logic             trig;

  // ----------------------------------------------------------------
  // Flag update; a trigger always beats a clear in the same cycle
  // ----------------------------------------------------------------
  always_comb begin
    s_d  = s_q;
    trig = |(shut_src & shut_en);            // see [RULE_11]
    if (sw_wr) begin
      s_d.shut = sw_val;                     // see [RULE_15]
    end
    if (restart_en && !trig) begin
      s_d.shut = 1'b0;                       // see [RULE_10]
    end
    if (trig) begin
      s_d.shut = 1'b1;
    end
  end

  // Starts up in shutdown so overrides hold the pins first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.shut <= `CWS_RST_SHUTDOWN;         // see [RULE_09]
    end else begin
      s_q <= s_d;
    end
  end

  assign shut = s_q.shut;
endmodule // cws_shutdown

`default_nettype wire

// ==== src/cws_top.sv ====
// Complementary waveform generator with APB register access,
// steering and bridge modes, dead band and shutdown overrides.
// Assumes all inputs are synchronous to pclk; pin direction is
// controlled outside this block.
//
// Overview of operation
// [RULE_01] The generator keeps running while the processor sleeps if its sources run.
// [RULE_02] With the internal fast oscillator as module clock, dead band works in sleep.
// [RULE_03] Software first makes all generator pins inputs so they stay inactive.
// [RULE_04] Software clears the enable bit before changing the configuration.
// [RULE_05] A three-bit mode field in control register 0 picks the output scheme.
// [RULE_06] Per-output polarity bits in control register 1 invert each output.
// [RULE_07] A four-bit field in the data-select register picks the data input.
// [RULE_08] In steering modes per-output steer bits pick which outputs carry data.
// [RULE_09] Two two-bit override fields set shutdown states; startup is in shutdown.
// [RULE_10] An auto-restart bit lets the generator leave shutdown by itself.
// [RULE_11] Per-source enable bits pick which inputs may force a shutdown.
// [RULE_12] Separate rising and falling dead-band counts set each edge's delay.
// [RULE_13] A clock-select register picks the clock that drives dead-band counting.
// [RULE_14] After enabling, software makes the generator pins outputs.
// [RULE_15] Auto-restart clears shutdown by hardware, else software clears it.
// [RULE_16] The falling count is six bits, n gives n to n+1 periods, zero bypasses.
// [RULE_17] In shutdown each output holds its override state whatever the data.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module cws_top
  import cws_pkg::*;
#(
  parameter int NUM_SRC = 16,
  parameter int OSC_DIV = `CWS_OSC_DIV
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_SRC-1:0] data_src,
  input  wire cws_quad_type       shut_src,
  input  wire logic               cpu_sleep,
  output cws_quad_type            pin_out,
  output cws_quad_type            pin_oe
);
  import cws_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (NUM_SRC < 1 || NUM_SRC > 16) begin : g_bad_src
      $error("NUM_SRC must lie in 1 to 16");
    end
    if (OSC_DIV < 1 || OSC_DIV > 255) begin : g_bad_div
      $error("OSC_DIV must lie in 1 to 255");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         en;
    cws_mode_type mode;
    cws_quad_type pol;
    cws_quad_type dsel;
    cws_quad_type steer;
    logic [1:0]   ovr_bd;
    logic [1:0]   ovr_ac;
    logic         restart_en;
    cws_quad_type shut_en;
    cws_count_type dbr;
    cws_count_type dbf;
    logic         clk_sel;
    logic [7:0]   div_cnt;
    logic         osc_tick;
    logic         data_prev;
    cws_quad_type steer_eff;
    logic         pp_phase;
    cws_quad_type pin_out;
    cws_quad_type pin_oe;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } cws_state_type;

  cws_state_type s_q;
  cws_state_type s_d;

  logic         shut;
  logic         sd_wr;
  logic         data;
  logic         tick;
  logic         wr_go;
  logic         mapped;
  logic [31:0]  rd_val;
  cws_quad_type wave;
  logic [1:0]   ovr_i;
  logic [1:0]   ov;

  cws_db_if db [2] ();

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Override decode to {enable, level}; inactive means the
  // polarity-adjusted idle level
  function automatic logic [1:0] ovr_pin(input logic [1:0] code,
                                         input logic       pol);
    unique case (code)
      `CWS_OVR_INACTIVE: ovr_pin = {1'b1, pol};
      `CWS_OVR_FLOAT:    ovr_pin = {1'b0, pol};
      `CWS_OVR_LOW:      ovr_pin = 2'h2;
      `CWS_OVR_HIGH:     ovr_pin = 2'h3;
    endcase
  endfunction

  // Address decode, used by both read and write paths
  function automatic logic addr_ok(input logic [7:0] a);
    unique case (a)
      `CWS_OFS_CONTROL0, `CWS_OFS_CONTROL1, `CWS_OFS_DATA_SEL,
      `CWS_OFS_AUTOSHUT0, `CWS_OFS_AUTOSHUT1, `CWS_OFS_RISE_DB,
      `CWS_OFS_FALL_DB, `CWS_OFS_CLK_SEL, `CWS_OFS_STATUS:
        addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Shutdown flag and dead-band stages
  // ----------------------------------------------------------------
  assign sd_wr = wr_go && (paddr == `CWS_OFS_AUTOSHUT0);

  cws_shutdown u_shutdown (
    .pclk       (pclk),
    .presetn    (presetn),
    .shut_src   (shut_src),
    .shut_en    (s_q.shut_en),
    .restart_en (s_q.restart_en),
    .sw_wr      (sd_wr),
    .sw_val     (pwdata[`CWS_BIT_SHUTDOWN]),
    .shut       (shut)
  );

  // Stage 0 delays the rising edge of the true side, stage 1 the
  // rising edge of the complement; falling edges pass at once
  assign db[0].raw      = data;
  assign db[0].rise_cnt = s_q.dbr;                   // see [RULE_12]
  assign db[1].raw      = ~data;
  assign db[1].rise_cnt = s_q.dbf;                   // see [RULE_16]

  generate
    for (genvar g = 0; g < 2; g++) begin : g_db
      assign db[g].fall_cnt = `CWS_RST_DB;
      assign db[g].tick     = tick;
      cws_deadband u_db (
        .pclk    (pclk),
        .presetn (presetn),
        .db      (db[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Data select and module clock tick
  // ----------------------------------------------------------------
  // Unconnected selections read as low
  assign data = (32'(s_q.dsel) < NUM_SRC) ?
                data_src[s_q.dsel] : 1'b0;           // see [RULE_07]

  // The system clock stops in sleep, the fast oscillator does not
  assign tick = s_q.clk_sel ? s_q.osc_tick
                            : ~cpu_sleep;  // see [RULE_13] [RULE_02]

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h00000000;
    unique case (paddr)
      `CWS_OFS_CONTROL0: rd_val = {24'h000000, s_q.en, 4'h0, s_q.mode};
      `CWS_OFS_CONTROL1: rd_val = {28'h0000000, s_q.pol};
      `CWS_OFS_DATA_SEL: rd_val = {28'h0000000, s_q.dsel};
      `CWS_OFS_AUTOSHUT0: rd_val = {24'h000000, shut, s_q.restart_en,
                                    s_q.ovr_bd, s_q.ovr_ac, 2'h0};
      `CWS_OFS_AUTOSHUT1: rd_val = {24'h000000, s_q.steer, s_q.shut_en};
      `CWS_OFS_RISE_DB:  rd_val = {26'h0000000, s_q.dbr};
      `CWS_OFS_FALL_DB:  rd_val = {26'h0000000, s_q.dbf};
      `CWS_OFS_CLK_SEL:  rd_val = {31'h00000000, s_q.clk_sel};
      `CWS_OFS_STATUS:   rd_val = {22'h000000, data, shut,
                                   s_q.pin_oe, s_q.pin_out};
      default:           rd_val = 32'h00000000;
    endcase
  end

  assign mapped = addr_ok(paddr);
  assign wr_go  = psel && penable && s_q.pready && pwrite && mapped;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d  = s_q;
    wave = 4'h0;
    ov   = 2'h0;

    // APB answers one cycle into the access phase
    s_d.pready  = psel && penable && !s_q.pready;
    s_d.pslverr = psel && penable && !s_q.pready && !mapped;
    if (psel && penable && !s_q.pready) begin
      s_d.prdata = mapped ? rd_val : 32'h00000000;
    end

    // Register writes
    if (wr_go) begin
      unique case (paddr)
        `CWS_OFS_CONTROL0: begin
          s_d.en   = pwdata[`CWS_BIT_EN];
          s_d.mode = cws_mode_type'(pwdata[2:0]);   // see [RULE_05]
        end
        `CWS_OFS_CONTROL1: s_d.pol = pwdata[3:0];   // see [RULE_06]
        `CWS_OFS_DATA_SEL: s_d.dsel = pwdata[3:0];  // see [RULE_07]
        `CWS_OFS_AUTOSHUT0: begin
          s_d.restart_en = pwdata[`CWS_BIT_RESTART]; // see [RULE_10]
          s_d.ovr_bd = pwdata[`CWS_BIT_OVR_BD +: 2]; // see [RULE_09]
          s_d.ovr_ac = pwdata[`CWS_BIT_OVR_AC +: 2];
        end
        `CWS_OFS_AUTOSHUT1: begin
          s_d.shut_en = pwdata[3:0];                 // see [RULE_11]
          s_d.steer   = pwdata[`CWS_BIT_STEER +: 4]; // see [RULE_08]
        end
        `CWS_OFS_RISE_DB:  s_d.dbr = pwdata[5:0];   // see [RULE_12]
        `CWS_OFS_FALL_DB:  s_d.dbf = pwdata[5:0];   // see [RULE_16]
        `CWS_OFS_CLK_SEL:  s_d.clk_sel = pwdata[0]; // see [RULE_13]
        default: ;
      endcase
    end

    // Fast oscillator divider; free-running, so sleep does not stop it
    s_d.osc_tick = 1'b0;
    if (s_q.div_cnt == 8'(OSC_DIV - 1)) begin
      s_d.div_cnt  = 8'h00;
      s_d.osc_tick = 1'b1;                           // see [RULE_02]
    end else begin
      s_d.div_cnt = s_q.div_cnt + 8'h01;
    end

    // Data edge tracking runs from pclk alone, so sleep is harmless
    s_d.data_prev = data;                            // see [RULE_01]
    if (data && !s_q.data_prev) begin
      s_d.steer_eff = s_q.steer;     // Sync steering waits for an edge
      s_d.pp_phase  = ~s_q.pp_phase;
    end

    // Output forming per mode
    unique case (s_q.mode)
      CWS_STEER_SYNC:  wave = {4{data}} & s_d.steer_eff; // see [RULE_08]
      CWS_STEER_ASYNC: wave = {4{data}} & s_q.steer;     // see [RULE_08]
      CWS_FULL_FWD:    wave = {data, 2'b00, 1'b1};
      CWS_FULL_REV:    wave = {2'b01, data, 1'b0};
      CWS_HALF_BRIDGE: wave = {db[1].delayed, db[0].delayed,
                               db[1].delayed, db[0].delayed};
      CWS_PUSH_PULL:   wave = {2'b00, data & s_d.pp_phase,
                               data & ~s_d.pp_phase};
      default:         wave = 4'h0;
    endcase

    // Pin stage: disabled is idle, shutdown forces overrides
    for (int i = 0; i < 4; i++) begin
      ovr_i = i[0] ? s_q.ovr_bd : s_q.ovr_ac;
      ov    = ovr_pin(ovr_i, s_q.pol[i]);
      if (!s_q.en) begin
        s_d.pin_out[i] = s_q.pol[i];
        s_d.pin_oe[i]  = 1'b1;
      end else if (shut) begin
        s_d.pin_out[i] = ov[0];                      // see [RULE_17]
        s_d.pin_oe[i]  = ov[1];                      // see [RULE_09]
      end else begin
        s_d.pin_out[i] = wave[i] ^ s_q.pol[i];       // see [RULE_06]
        s_d.pin_oe[i]  = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.mode <= CWS_STEER_SYNC;
      s_q.dbr  <= `CWS_RST_DB;
      s_q.dbf  <= `CWS_RST_DB;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pin_out = s_q.pin_out;
  assign pin_oe  = s_q.pin_oe;
endmodule // cws_top

`default_nettype wire

// ==== verif/cws_top_assertions.sv ====
// Checker for the waveform block: bus timing, read-back and overrides.
// Assumes a bind onto cws_top; one clock, reset active low.
`timescale 1ns/100ps
`default_nettype none
`include "cws_params.svh"

module cws_top_assertions (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire cws_pkg::cws_quad_type shut_src,
  input wire cws_pkg::cws_quad_type pin_out,
  input wire cws_pkg::cws_quad_type pin_oe
);
  import cws_pkg::*;
  logic       en_q;
  logic [3:0] src_q;
  logic [3:0] ovr_q;
  logic       wr_ok;
  logic       rd_ok;

  // --------
  // Shadow of the setup
  // --------
  // Copies taken where the slave takes a write
  assign wr_ok = psel && penable && pready && pwrite;
  assign rd_ok = psel && penable && pready && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q  <= 1'b0;
      src_q <= 4'h0;
      ovr_q <= 4'h0;
    end else if (wr_ok) begin
      if (paddr == `CWS_OFS_CONTROL0) en_q <= pwdata[7];
      if (paddr == `CWS_OFS_AUTOSHUT1) src_q <= pwdata[3:0];
      if (paddr == `CWS_OFS_AUTOSHUT0) ovr_q <= pwdata[3:0];
    end
  end

  // --------
  // Properties
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_trip;
    en_q && |(shut_src & src_q);
  endsequence

  AST_PREADY_TIME: assert property (s_setup ##1 (psel && penable) |=> pready)
    else $error("pready not one cycle into access");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_SLVERR_PAIR: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  AST_UNMAPPED: assert property (rd_ok && paddr > `CWS_OFS_STATUS
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_PRDATA_HOLD: assert property (!pready |-> $stable(prdata))
    else $error("read data moved between reads");
  AST_RESET_IDLE: assert property (!$past(presetn)
    |=> pin_oe == 4'hF && pin_out == 4'h0)
    else $error("pins not idle after reset");
  AST_STATUS_MIRROR: assert property (rd_ok && paddr == `CWS_OFS_STATUS
    && $stable(pin_out) && $stable(pin_oe) |-> prdata[7:0] == {pin_oe, pin_out})
    else $error("status does not mirror pins");
  AST_FALL_WIDTH: assert property (rd_ok && paddr == `CWS_OFS_FALL_DB
    |-> prdata[31:6] == 26'h0)
    else $error("falling count wider than six bits");
  AST_OVERRIDE_A: assert property (s_trip ##1 s_trip
    |-> ##2 (!ovr_q[3] || pin_out[0] == ovr_q[2]))
    else $error("output A not at override level");
endmodule // cws_top_assertions

`default_nettype wire

// ==== verif/cws_stage_model.sv ====
// Power stage model: resolves each pad from the block's drive, its
// enable and the pin direction software sets. Assumes clock pclk.
`timescale 1ns/100ps
`default_nettype none

module cws_stage_model (
  input  wire logic                  pclk,
  input  wire cws_pkg::cws_quad_type drive,
  input  wire cws_pkg::cws_quad_type drive_en,
  input  wire cws_pkg::cws_quad_type pin_dir,
  output cws_pkg::cws_quad_type      pad
);
  import cws_pkg::*;
  cws_quad_type flt_q = 4'h5;
  cws_quad_type on;

  // Released pads wander, so a stale level cannot pass for a drive
  always @(posedge pclk) flt_q <= ~flt_q;
  // A pin set as input never drives the stage
  assign on  = drive_en & ~pin_dir;
  assign pad = (drive & on) | (flt_q & ~on);
endmodule // cws_stage_model

`default_nettype wire

// ==== verif/test_complementary_waveform_setup.sv ====
// Self-checking bench: registers over APB, pins through the stage.
// Assumes the checker and stage model are compiled beforehand.
`timescale 1ns/100ps
`default_nettype none
`include "cws_params.svh"

module test_complementary_waveform_setup;
  import cws_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         cpu_sleep, err_v;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd_v;
  logic [15:0]  data_src;
  cws_quad_type shut_src, pin_out, pin_oe, pin_dir, pad;
  int           fails, checks, k, n, v, cnt;

  cws_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_src(data_src), .shut_src(shut_src), .cpu_sleep(cpu_sleep),
    .pin_out(pin_out), .pin_oe(pin_oe));
  cws_stage_model stage (.pclk(pclk), .drive(pin_out), .drive_en(pin_oe),
    .pin_dir(pin_dir), .pad(pad));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // --------
  // Tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkp(input cws_quad_type got, input cws_quad_type exp);
    chk({28'h0, got}, {28'h0, exp});
  endtask
  function automatic cws_quad_type lvl(input logic b, input cws_quad_type p);
    return {4{b}} ^ p;
  endfunction
  // Holds the request until pready is seen high or 20 cycles pass
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) fails++;
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // --------
  // Main sequence
  // --------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cpu_sleep} = '0;
    {data_src, shut_src, presetn, fails, checks} = '0;
    pin_dir = 4'hF;
    rd_v = $urandom(32'h680d);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and a refused address
    apb(1'b0, `CWS_OFS_FALL_DB, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b0, `CWS_OFS_STATUS, 32'h0);
    chk(rd_v & 32'h100, 32'h100);
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
    // Both dead-band counts keep six bits
    for (k = 0; k < 2; k++) begin
      v = $urandom;
      apb(1'b1, `CWS_OFS_RISE_DB + 8'(4 * k), v);
      apb(1'b0, `CWS_OFS_RISE_DB + 8'(4 * k), 32'h0);
      chk(rd_v, v & 32'h3F);
    end
    // Every mode code, written while disabled
    for (k = 0; k < 8; k++) begin
      apb(1'b1, `CWS_OFS_CONTROL0, k);
      apb(1'b0, `CWS_OFS_CONTROL0, 32'h0);
      chk(rd_v, 32'(k));
    end
    // Steer all, source 0 enabled, shutdown set by software, B/D override high, A/C low
    k = $urandom_range(15);
    apb(1'b1, `CWS_OFS_DATA_SEL, k);
    apb(1'b1, `CWS_OFS_AUTOSHUT0, 32'hB8);
    apb(1'b1, `CWS_OFS_AUTOSHUT1, 32'hF1);
    apb(1'b1, `CWS_OFS_CLK_SEL, 32'h0);
    apb(1'b1, `CWS_OFS_CONTROL0, 32'h81);
    pin_dir <= 4'h0;
    shut_src <= 4'h2;
    repeat (4) @(posedge pclk);
    chkp(pad, 4'hA);
    apb(1'b1, `CWS_OFS_AUTOSHUT0, 32'h38);
    // Unenabled source stays quiet; data follows with no inversion, then with A and C inverted
    for (n = 0; n < 16; n++) begin
      if (n % 8 == 0) apb(1'b1, `CWS_OFS_CONTROL1, n ? 32'h5 : 32'h0);
      cpu_sleep <= (n >= 8);
      data_src <= 16'($urandom);
      repeat (2) @(posedge pclk);
      chkp(pad, lvl(data_src[k], n >= 8 ? 4'h5 : 4'h0));
    end
    // Trip, hold without restart, then clear by a write with bit 7 low that also sets restart
    apb(1'b1, `CWS_OFS_CONTROL1, 32'h0);
    shut_src <= 4'h1;
    repeat (4) @(posedge pclk);
    chkp(pad, 4'hA);
    shut_src <= 4'h0;
    data_src <= ~data_src;
    repeat (4) @(posedge pclk);
    chkp(pad, 4'hA);
    apb(1'b1, `CWS_OFS_AUTOSHUT0, 32'h78);
    apb(1'b0, `CWS_OFS_STATUS, 32'h0);
    chk(rd_v & 32'h100, 32'h0);
    // Half bridge delay on system clock, then fast clock in sleep
    for (n = 0; n < 2; n++) begin
      v = $urandom_range(6);
      apb(1'b1, `CWS_OFS_RISE_DB, v);
      apb(1'b1, `CWS_OFS_CLK_SEL, n);
      apb(1'b1, `CWS_OFS_CONTROL0, 32'h84);
      cpu_sleep <= 1'(n);
      data_src <= 16'h0;
      repeat (30) @(posedge pclk);
      data_src <= 16'hFFFF;
      cnt = 0;
      do begin
        @(posedge pclk);
        cnt++;
      end while (pin_out[0] !== 1'b1 && cnt < 200);
      chk(32'(cnt > v && cnt <= (v + 2) * (n ? `CWS_OSC_DIV : 1) + 2), 32'h1);
    end
    // Full bridge forward and reverse with data held high
    for (n = 2; n < 4; n++) begin
      apb(1'b1, `CWS_OFS_CONTROL0, 32'h80 + n);
      repeat (2) @(posedge pclk);
      chkp(pin_out, n == 2 ? 4'h9 : 4'h6);
      chkp(pin_oe, 4'hF);
    end
    final_report;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report;
  end
endmodule // test_complementary_waveform_setup

bind cws_top cws_top_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shut_src(shut_src), .pin_out(pin_out), .pin_oe(pin_oe));

`default_nettype wire
